// [tec_pkg.sv]
package tec_pkg;
  // Control register field positions
  localparam int CTL_PSC_LSB  = 0;
  localparam int CTL_PSC_MSB  = 2;
  localparam int CTL_EDGE_BIT = 3;
  localparam int CTL_RUN_BIT  = 4;
  localparam int CTL_MODE_LO  = 6;
  localparam int CTL_MODE_HI  = 7;
  // Interrupt control bit positions
  localparam int INTERRUPT_CONTROL_ETI_BIT = 2;
  localparam int INTERRUPT_CONTROL_TF_BIT  = 5;
  // Values after reset, plus the counter's full value
  localparam logic [7:0] CTL_RESET     = 8'h00;
  localparam logic [7:0] PRELOAD_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] COUNT_FULL    = 8'hFF;
  localparam logic [6:0] PSC_RESET     = 7'h00;

  typedef enum logic [1:0] {
    TEC_MODE_IDLE,
    TEC_MODE_EVENT,
    TEC_MODE_TIMER,
    TEC_MODE_PULSE
  } tec_mode_t;

  typedef struct packed {
    logic       wrCount;
    logic       rdCount;
    logic       wrCtl;
    logic [7:0] wdata;
  } tec_sw_t;

  typedef struct packed {
    logic tone;
    logic toneN;
    logic toneOe;
    logic toneNOe;
  } tec_tone_t;
endpackage

// [tec_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RULE1] One 8-bit counter, counts up by one per qualifying pulse or edge.
// [RULE2] Writing count loads preload; reading count returns live counter.
// [RULE3] Past FF the counter overflows, flags interrupt, reloads preload, keeps going.
// [RULE4] Preload write while stopped also loads counter; else waits for overflow.
// [RULE5] Counting is suppressed during a count register read.
// [RULE6] Control bit 4 runs the counter when set, halts it when clear.
// [RULE7] Control bits 0-2 pick prescale ratio; ignored in event counting.
// [RULE8] Control bit 3 picks external edge polarity for event and pulse modes.
// [RULE9] Mode 10: count prescaled clock on falling edges of divided clock.
// [RULE10] Mode 01: event counting from the external timer pin.
// [RULE11] Event mode: rising edges when edge select low, falling when high.
// [RULE12] Mode 11: count prescaled clock between start edge and return level.
// [RULE13] Pulse mode: edge low starts falling; edge high starts rising.
// [RULE14] Pulse end clears run bit; pin ignored until software sets it again.
// [RULE15] Timer and event modes never clear the run bit in hardware.
// [RULE16] Pulse mode samples prescaler output once per machine phase tick.
// [RULE17] Software sets the external pin as input before event or pulse modes.
// [RULE18] Each overflow toggles tone pair; inverted output is complementary while bit 0 latch is 1.
// [RULE19] Tone pins drive only when port B direction bits 0 and 1 are outputs.
// [RULE20] Tone toggles only while bit 0 latch is 1; both low when 0.
// [RULE21] Overflow is a wake-up source; interrupt gated by timer interrupt enable.
// [RULE22] Every overflow sets timer interrupt flag at interrupt control bit 5.
// [RULE23] Prescaler divides by two to the power of prescale select, 1 to 128.
module tec_timer #(
  parameter int PSC_STAGES = 7
) (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire tec_pkg::tec_sw_t sw,
  input  wire logic           extPin,
  input  wire logic           tfClear,
  input  wire logic           timerIrqEnable,
  input  wire logic [1:0]     portBDirection,
  input  wire logic           portBBit0Latch,
  input  wire logic           portBBit1Latch,
  output logic [7:0]          countRdata,
  output logic [7:0]          ctlRdata,
  output logic                timerIrqFlag,
  output logic                timerIrq,
  output logic                wakeUp,
  output tec_pkg::tec_tone_t  toneBus
);
  import tec_pkg::*;

  // Ratios 1 to 128 need exactly seven ripple stages
  if (PSC_STAGES != 7) begin : g_psc_check
    $error("tec_timer: prescaler must have 7 divide stages");
  end

  logic [7:0]            countReg;
  logic [7:0]            preloadReg;
  logic [7:0]            ctlReg;
  logic [PSC_STAGES-1:0] pscReg;
  logic                  pinReg;
  logic                  divReg;
  logic                  toneReg;
  logic                  tfReg;
  logic                  irqReg;
  logic                  wakeReg;
  logic [7:0]            countRdReg;
  tec_tone_t             toneBusReg;
  logic                  pulseOnReg;

  function automatic tec_mode_t decodeMode(input logic [7:0] c);
    case ({c[CTL_MODE_HI], c[CTL_MODE_LO]})
      2'b01:   decodeMode = TEC_MODE_EVENT;
      2'b10:   decodeMode = TEC_MODE_TIMER;
      2'b11:   decodeMode = TEC_MODE_PULSE;
      default: decodeMode = TEC_MODE_IDLE;
    endcase
  endfunction

  tec_mode_t mode;
  wire       runBit  = ctlReg[CTL_RUN_BIT];                         // RULE6
  wire       edgeSel = ctlReg[CTL_EDGE_BIT];                        // RULE8
  wire [2:0] pscSel  = ctlReg[CTL_PSC_MSB:CTL_PSC_LSB];
  assign mode = decodeMode(ctlReg);

  // Divide-by-2^n: tap bit n-1 of the ripple count, n=0 is every cycle
  wire [PSC_STAGES-1:0] pscNext = pscReg + 1'b1;                   // RULE23
  wire divNow  = (pscSel == 3'h0) ? 1'b0 : pscReg[pscSel - 3'h1];   // RULE7
  wire divFall = (pscSel == 3'h0) ? 1'b1 : (divReg & ~divNow);      // RULE9 RULE16
  wire pinRise = ~pinReg & extPin;
  wire pinFall = pinReg & ~extPin;
  wire evEdge  = edgeSel ? pinFall : pinRise;                      // RULE11
  // Active level of a pulse: low for falling start, high for rising start
  wire pulseActive = edgeSel ? extPin : ~extPin;                   // RULE13
  wire pulseEnd    = edgeSel ? pinFall : pinRise;                   // RULE13
  // A level alone never starts a measurement, only the start edge
  wire pulseStart  = edgeSel ? pinRise : pinFall;                   // RULE12 RULE13
  wire pulseOn     = pulseOnReg | pulseStart;                       // RULE12

  logic tick;
  always_comb begin
    case (mode)
      TEC_MODE_TIMER: tick = divFall;                              // RULE9
      TEC_MODE_EVENT: tick = evEdge;                               // RULE10 RULE11
      TEC_MODE_PULSE: tick = divFall & pulseActive & pulseOn & ~pulseEnd; // RULE12 RULE16
      default:        tick = 1'b0;
    endcase
  end

  // Read freezes the count; ticks in that cycle are lost by design
  wire advance  = runBit & tick & ~sw.rdCount;                     // RULE5 RULE6
  wire overflow = advance & (countReg == COUNT_FULL);               // RULE3
  wire stopPulse = runBit & (mode == TEC_MODE_PULSE) & pulseEnd & pulseOnReg; // RULE14
  wire pulseOnNext = runBit & (mode == TEC_MODE_PULSE) & pulseOn & ~pulseEnd; // RULE12 RULE14
  wire toneNext  = portBBit0Latch ? (toneReg ^ overflow) : 1'b0;    // RULE18 RULE20

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pscReg <= PSC_RESET;
      divReg <= 1'b0;
      pinReg <= 1'b1;
      pulseOnReg <= 1'b0;
    end else begin
      pscReg <= pscNext;
      divReg <= divNow;
      pinReg <= extPin;
      pulseOnReg <= pulseOnNext;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      preloadReg <= PRELOAD_RESET;
    end else if (sw.wrCount) begin
      preloadReg <= sw.wdata;                                      // RULE2
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      countReg <= COUNT_RESET;
    end else if (sw.wrCount && !runBit) begin
      countReg <= sw.wdata;                                        // RULE4
    end else if (overflow) begin
      countReg <= preloadReg;                                      // RULE3 RULE4
    end else if (advance) begin
      countReg <= countReg + 8'h01;                                // RULE1
    end
  end

  // Software write wins over the hardware stop; run clears only in pulse mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctlReg <= CTL_RESET;
    end else if (sw.wrCtl) begin
      ctlReg <= sw.wdata;
    end else if (stopPulse) begin
      ctlReg[CTL_RUN_BIT] <= 1'b0;                                 // RULE14 RULE15
    end
  end

  // Set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tfReg   <= 1'b0;
      irqReg  <= 1'b0;
      wakeReg <= 1'b0;
    end else begin
      tfReg   <= overflow | (tfReg & ~tfClear);                    // RULE22
      irqReg  <= (overflow | (tfReg & ~tfClear)) & timerIrqEnable; // RULE21
      wakeReg <= overflow;                                         // RULE21
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      toneReg    <= 1'b0;
      toneBusReg <= '0;
      countRdReg <= COUNT_RESET;
    end else begin
      toneReg            <= toneNext;
      toneBusReg.tone    <= toneNext;                              // RULE18
      toneBusReg.toneN   <= portBBit0Latch ? ~toneNext : 1'b0;     // RULE18 RULE20
      toneBusReg.toneOe  <= ~portBDirection[0];                    // RULE19
      toneBusReg.toneNOe <= ~portBDirection[1];                    // RULE19
      countRdReg         <= countReg;                              // RULE2
    end
  end

  assign countRdata   = countRdReg;
  assign ctlRdata     = ctlReg;
  assign timerIrqFlag = tfReg;
  assign timerIrq     = irqReg;
  assign wakeUp       = wakeReg;
  assign toneBus      = toneBusReg;

  wire unusedLatch = portBBit1Latch;                               // RULE20

  property p_overflow_reload;
    @(posedge clk) disable iff (rst)
      (overflow && !sw.wrCount) |=> (countReg == $past(preloadReg));
  endproperty
  a_overflow_reload: assert property (p_overflow_reload) // RULE3
    else $error("counter did not reload on overflow");

  property p_flag_set;
    @(posedge clk) disable iff (rst) overflow |=> tfReg;
  endproperty
  a_flag_set: assert property (p_flag_set) // RULE22
    else $error("overflow did not set interrupt flag");

  property p_read_freeze;
    @(posedge clk) disable iff (rst)
      (sw.rdCount && !sw.wrCount) |=> $stable(countReg);
  endproperty
  a_read_freeze: assert property (p_read_freeze) // RULE5
    else $error("counter moved during read");

  property p_stopped_load;
    @(posedge clk) disable iff (rst)
      (sw.wrCount && !runBit) |=> (countReg == $past(sw.wdata));
  endproperty
  a_stopped_load: assert property (p_stopped_load) // RULE4
    else $error("stopped write not copied to counter");

  property p_halt;
    @(posedge clk) disable iff (rst)
      (!runBit && !sw.wrCount) |=> $stable(countReg);
  endproperty
  a_halt: assert property (p_halt) // RULE6
    else $error("counter moved while halted");

  property p_run_kept;
    @(posedge clk) disable iff (rst)
      (runBit && mode != TEC_MODE_PULSE && !sw.wrCtl) |=> runBit;
  endproperty
  a_run_kept: assert property (p_run_kept) // RULE15
    else $error("run bit cleared by hardware outside pulse mode");

  property p_pulse_stop;
    @(posedge clk) disable iff (rst) (stopPulse && !sw.wrCtl) |=> !runBit;
  endproperty
  a_pulse_stop: assert property (p_pulse_stop) // RULE14
    else $error("run bit not cleared at pulse end");

  property p_tone_pair;
    @(posedge clk) disable iff (rst)
      portBBit0Latch |=> (toneBus.toneN == ~toneBus.tone);
  endproperty
  a_tone_pair: assert property (p_tone_pair) // RULE18
    else $error("tone outputs not complementary");

  property p_tone_low;
    @(posedge clk) disable iff (rst)
      !portBBit0Latch |=> (!toneBus.tone && !toneBus.toneN);
  endproperty
  a_tone_low: assert property (p_tone_low) // RULE20
    else $error("tone outputs not low with latch clear");

  property p_event_count;
    @(posedge clk) disable iff (rst)
      (mode == TEC_MODE_EVENT && runBit && evEdge && !sw.rdCount && !sw.wrCount
       && countReg != COUNT_FULL) |=> (countReg == $past(countReg) + 8'h01);
  endproperty
  a_event_count: assert property (p_event_count) // RULE11
    else $error("event edge did not advance counter");

  property p_count_step;
    @(posedge clk) disable iff (rst)
      (advance && !overflow) |=> (countReg == $past(countReg) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) // RULE1
    else $error("counter did not step by one");

  property p_timer_tick;
    @(posedge clk) disable iff (rst)
      (mode == TEC_MODE_TIMER && runBit && !divFall) |=> $stable(countReg);
  endproperty
  a_timer_tick: assert property (p_timer_tick) // RULE9
    else $error("timer counted without a divided clock fall");

  property p_event_edges;
    @(posedge clk) disable iff (rst)
      (mode == TEC_MODE_EVENT && runBit && !evEdge) |=> $stable(countReg);
  endproperty
  a_event_edges: assert property (p_event_edges) // RULE10
    else $error("event counter moved without a pin edge");

  property p_pulse_wait;
    @(posedge clk) disable iff (rst)
      (mode == TEC_MODE_PULSE && runBit && !pulseOn) |=> $stable(countReg);
  endproperty
  a_pulse_wait: assert property (p_pulse_wait) // RULE12
    else $error("pulse count began without a start edge");

  property p_irq_gate;
    @(posedge clk) disable iff (rst) !timerIrqEnable |=> !timerIrq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // RULE21
    else $error("interrupt raised while disabled");

  property p_wake;
    @(posedge clk) disable iff (rst) overflow |=> wakeUp;
  endproperty
  a_wake: assert property (p_wake) // RULE21
    else $error("overflow did not raise wake-up");

  property p_tone_off;
    @(posedge clk) disable iff (rst)
      (portBDirection == 2'b11) |=> (!toneBus.toneOe && !toneBus.toneNOe);
  endproperty
  a_tone_off: assert property (p_tone_off) // RULE19
    else $error("tone pins driven while set as inputs");

  property p_flag_hold;
    @(posedge clk) disable iff (rst) (tfReg && !tfClear) |=> tfReg;
  endproperty
  a_flag_hold: assert property (p_flag_hold) // RULE22
    else $error("interrupt flag dropped without a clear");
endmodule
`default_nettype wire

// [tec_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module tec_partner (
  input  wire tec_pkg::tec_tone_t toneBus,
  input  wire logic               clk,
  output logic                    extPin,
  output int                      toneEdges
);
  import tec_pkg::*;
  logic toneLast = 1'b0;
  initial extPin = 1'b1;
  initial toneEdges = 0;
  // Pin moves only at negedges, well clear of the sampling edge
  task automatic drive(input logic lvl, input int hold);
    @(negedge clk);
    extPin = lvl;
    repeat (hold) @(negedge clk);
  endtask
  // Piezo only hears toggles while the tone pin (toneOe) is actually driven
  always @(posedge clk) begin
    if (toneBus.toneOe && toneBus.tone !== toneLast) toneEdges <= toneEdges + 1;
    toneLast <= toneBus.tone;
  end
endmodule
`default_nettype wire

// [tec_timer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tec_timer_tb;
  import tec_pkg::*;
  logic       clk, rst, tfClear, irqEn, latch0, latch1, extPin;
  logic       timerIrqFlag, timerIrq, wakeUp;
  logic [1:0] dir;
  logic [7:0] countRdata, ctlRdata, v0, v1;
  tec_sw_t    sw;
  tec_tone_t  toneBus;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         toneEdges, e0;

  tec_timer dut (.clk(clk), .rst(rst), .sw(sw), .extPin(extPin), .tfClear(tfClear),
    .timerIrqEnable(irqEn), .portBDirection(dir), .portBBit0Latch(latch0),
    .portBBit1Latch(latch1), .countRdata(countRdata), .ctlRdata(ctlRdata),
    .timerIrqFlag(timerIrqFlag), .timerIrq(timerIrq), .wakeUp(wakeUp), .toneBus(toneBus));
  tec_partner partner (.clk(clk), .toneBus(toneBus), .extPin(extPin), .toneEdges(toneEdges));

  task automatic summarize;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic isCtl, input logic [7:0] d);
    @(negedge clk);
    sw.wdata = d;
    sw.wrCtl = isCtl;
    sw.wrCount = !isCtl;
    @(negedge clk);
    sw.wrCtl = 1'b0;
    sw.wrCount = 1'b0;
  endtask
  // Read data lags one cycle, so the strobe spans two edges
  task automatic rd(output logic [7:0] d);
    @(negedge clk);
    sw.rdCount = 1'b1;
    repeat (2) @(negedge clk);
    d = countRdata;
    sw.rdCount = 1'b0;
  endtask
  task automatic waitWake(input int bound);
    int i;
    for (i = 0; i < bound && wakeUp !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    if (i == bound) begin
      n_mismatch++;
      $display("wrong value at %0t: no overflow seen", $time);
      summarize();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    sw = '0;
    tfClear = 1'b0;
    irqEn = 1'b0;
    dir = 2'b11;
    latch0 = 1'b1;
    latch1 = 1'b0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk(ctlRdata, CTL_RESET);
    rd(v0);
    chk(v0, COUNT_RESET);
    wr(1'b1, 8'h83);
    wr(1'b0, 8'hFC);
    rd(v0);
    chk(v0, 8'hFC);
    dir = 2'b00;
    e0 = toneEdges;
    wr(1'b1, 8'h93);
    waitWake(60);
    chk({7'h00, timerIrqFlag}, 8'h01);
    chk({7'h00, timerIrq}, 8'h00);
    irqEn = 1'b1;
    @(negedge clk);
    chk({7'h00, timerIrq}, 8'h01);
    chk({6'h00, toneBus.tone ^ toneBus.toneN, toneBus.toneOe & toneBus.toneNOe}, 8'h03);
    rd(v0);
    chk({1'b0, v0[7:1]}, 8'h7E);
    // Running: new preload must not disturb the live count
    wr(1'b0, 8'h40);
    rd(v1);
    chk({7'h00, v1 >= 8'hFC}, 8'h01);
    @(negedge clk);
    tfClear = 1'b1;
    @(negedge clk);
    tfClear = 1'b0;
    chk({7'h00, timerIrqFlag}, 8'h00);
    waitWake(60);
    rd(v0);
    chk({1'b0, v0[7:1]}, 8'h20);
    chk({7'h00, toneEdges - e0 == 2}, 8'h01);
    chk(ctlRdata, 8'h93);
    repeat (80) @(negedge clk);
    rd(v1);
    chk({7'h00, (v1 - v0) inside {[8'h09:8'h0B]}}, 8'h01);
    wr(1'b1, 8'h90);
    @(negedge clk);
    sw.rdCount = 1'b1;
    repeat (2) @(negedge clk);
    v0 = countRdata;
    repeat (6) @(negedge clk);
    chk(countRdata, v0);
    sw.rdCount = 1'b0;
    latch0 = 1'b0;
    latch1 = 1'b1;
    repeat (3) @(negedge clk);
    chk({6'h00, toneBus.tone, toneBus.toneN}, 8'h00);
    dir = 2'b11;
    repeat (3) @(negedge clk);
    chk({6'h00, toneBus.toneOe, toneBus.toneNOe}, 8'h00);
    wr(1'b1, 8'h80);
    rd(v0);
    repeat (20) @(negedge clk);
    rd(v1);
    chk(v1, v0);
    // Prescale bits set on purpose: edges must still count one each
    wr(1'b1, 8'h47);
    wr(1'b0, 8'h10);
    for (int k = 0; k < 2; k++) begin
      wr(1'b1, k ? 8'h5F : 8'h57);
      partner.drive(k ? 1'b1 : 1'b0, 3);
      partner.drive(k ? 1'b0 : 1'b1, 3);
      rd(v0);
      chk(v0, k ? 8'h12 : 8'h11);
    end
    partner.drive(1'b1, 3);
    wr(1'b1, 8'hC0);
    wr(1'b0, 8'h00);
    wr(1'b1, 8'hD0);
    partner.drive(1'b0, 20);
    partner.drive(1'b1, 3);
    rd(v0);
    chk({7'h00, v0 inside {[8'h13:8'h16]}}, 8'h01);
    chk(ctlRdata, 8'hC0);
    partner.drive(1'b0, 8);
    partner.drive(1'b1, 3);
    rd(v1);
    chk(v1, v0);
    wr(1'b1, 8'hD8);
    partner.drive(1'b0, 10);
    partner.drive(1'b1, 12);
    partner.drive(1'b0, 3);
    rd(v1);
    chk({7'h00, (v1 - v0) inside {[8'h0B:8'h0E]}}, 8'h01);
    chk(ctlRdata, 8'hC8);
    summarize();
  end
endmodule
`default_nettype wire
